// >>> logic/hbt_cfg.svh
// Purpose: offsets, field positions, reset values and fixed figures of the host bridge translator
// Assumes: 32-bit avalon register words at byte offsets
// Notes: included by hbt_pio_xlate and hbt_bridge; hbt_pkg and hbt_tce_cache do not include it
`ifndef HBT_CFG_SVH
`define HBT_CFG_SVH

// register byte offsets
`define HBT_REG_CTRL 6'h00
`define HBT_REG_IO_BASE 6'h04
`define HBT_REG_IO_TOP 6'h08
`define HBT_REG_PM_BASE 6'h0c
`define HBT_REG_PM_TOP 6'h10
`define HBT_REG_TCE_BASE 6'h14
`define HBT_REG_PC_CEIL 6'h18
`define HBT_REG_EXC_BASE 6'h1c
`define HBT_REG_MEM_TOP 6'h20
`define HBT_REG_STATUS 6'h24
`define HBT_REG_TCE_STORE 6'h28

// control bit positions
`define HBT_CTRL_DISCONTIG 0
`define HBT_CTRL_DMA64 1
`define HBT_CTRL_PCEMU 2
`define HBT_CTRL_PM_ALIAS 3
`define HBT_CTRL_SM_ALIAS 4
`define HBT_CTRL_IO_HOLE 5
`define HBT_CTRL_RESET 6'h00

// status bit positions
`define HBT_ST_INVALID 0
`define HBT_ST_TCE_ERR 1
`define HBT_ST_IGNORED 2

// address figures
`define HBT_IO_LOW_SPAN 32'h0001_0000
`define HBT_IO_HIGH_START 32'h0080_0000
`define HBT_PAGE_BITS 12
`define HBT_BLOCK_BITS 5
`define HBT_MB_BITS 20
`define HBT_EXC_TOP_BASE 32'hfff0_0000
`define HBT_EXC_SIZE_MIN 32'h0000_3000
`define HBT_TCE_SHIFT 3
`define HBT_PM_NONE 2'h0
`define HBT_UPPER_ONES 32'hffff_ffff

`endif

// >>> logic/hbt_pkg.sv
// Purpose: types shared by the host bridge translator files
// Assumes: nothing beyond hbt_cfg.svh for numbers
// Notes: carriers for dma requests and answers
package hbt_pkg;

	// dma translation sequencer
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CHECK,
		ST_FETCH,
		ST_WAIT,
		ST_FIN,
		ST_FLUSH,
		ST_INVAL
	} hbt_state_e;

	// outcome of one dma access
	typedef enum logic [1:0] {
		RES_OK,
		RES_INVALID,
		RES_TCE_ERR,
		RES_IGNORED
	} hbt_res_e;

	// dma request from the i/o bus side
	typedef struct packed {
		logic [63:0] addr;
		logic dac;
		logic write;
	} hbt_dma_req_s;

	// dma answer toward the host side
	typedef struct packed {
		logic [63:0] addr;
		hbt_res_e res;
		logic write;
	} hbt_dma_out_s;

endpackage

// >>> logic/hbt_pio_xlate.sv
// Purpose: processor access decode into i/o space or relocated exception area
// Assumes: window base and top are inclusive byte addresses
// Notes: purely combinational; the top module registers the result
`include "hbt_cfg.svh"
module hbt_pio_xlate
	import hbt_pkg::*;
#(
	parameter logic [31:0] EXC_SIZE = `HBT_EXC_SIZE_MIN
) (
	// request
	input wire logic [31:0] addr,
	// configuration
	input wire logic [31:0] io_window_base,
	input wire logic [31:0] io_window_top,
	input wire logic [31:0] exc_base,
	input wire logic discontig,
	input wire logic pcemu,
	// result
	output logic io_hit,
	output logic sys_hit,
	output logic [31:0] out_addr
);
	logic [31:0] off;
	logic [31:0] exc_off;

	// offset into the window and into the exception area
	assign off = addr - io_window_base;
	assign exc_off = addr - `HBT_EXC_TOP_BASE;

	// window map; the gap between 64 KB and 8 MB stays unmapped in contiguous mode
	always_comb begin
		io_hit = 1'b0;
		sys_hit = 1'b0;
		out_addr = 32'h0;
		if (pcemu && addr >= `HBT_EXC_TOP_BASE && exc_off < EXC_SIZE) begin
			sys_hit = 1'b1;
			out_addr = exc_base + exc_off;
		end else if (addr >= io_window_base && addr <= io_window_top) begin
			if (off >= `HBT_IO_HIGH_START) begin
				io_hit = 1'b1;
				out_addr = off;
			end else if (discontig) begin
				io_hit = 1'b1;
				out_addr = {16'h0, off[22:`HBT_PAGE_BITS], off[`HBT_BLOCK_BITS-1:0]};
			end else if (off < `HBT_IO_LOW_SPAN) begin
				io_hit = 1'b1;
				out_addr = off;
			end
		end
	end
endmodule

// >>> logic/hbt_tce_cache.sv
// Purpose: single-entry cache of the last translation entry fetched
// Assumes: entries arrive already in native order
// Notes: a fill and an invalidate never come in the same cycle
module hbt_tce_cache
	import hbt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// lookup
	input wire logic [19:0] look_page,
	output logic hit,
	output logic [63:0] hit_tce,
	// fill and invalidate
	input wire logic fill,
	input wire logic [19:0] fill_page,
	input wire logic [63:0] fill_tce,
	input wire logic inval,
	input wire logic [19:0] inval_page
);
	logic valid;
	logic [19:0] tag;
	logic [63:0] data;

	// one entry keeps the area small; streaming dma within a page still hits
	always_ff @(posedge clk) begin
		if (rst) begin
			valid <= 1'b0;
		end else if (inval && inval_page == tag) begin
			valid <= 1'b0;
		end else if (fill) begin
			valid <= 1'b1;
		end
	end

	// tag and data need no reset, valid guards them
	always_ff @(posedge clk) begin
		if (fill) begin
			tag <= fill_page;
			data <= fill_tce;
		end
	end

	assign hit = valid && tag == look_page;
	assign hit_tce = data;
endmodule

// >>> logic/hbt_bridge.sv
// Purpose: host bridge address translation for processor and dma traffic
// Assumes: one clock; memory and flush ports answer on the same clock
// Notes: registers reached over avalon-mm with waitrequest
`include "hbt_cfg.svh"
module hbt_bridge
	import hbt_pkg::*;
#(
	parameter logic [31:0] EXC_SIZE = `HBT_EXC_SIZE_MIN,
	parameter bit PCE_RESPOND = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// avalon-mm register slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// processor access
	input wire logic cpu_valid,
	input wire logic [31:0] cpu_addr,
	output logic cpu_out_valid,
	output logic cpu_out_io,
	output logic cpu_out_miss,
	output logic [31:0] cpu_out_addr,
	// dma request and answer
	input wire logic dma_valid,
	input wire hbt_dma_req_s dma_req,
	output logic dma_ready,
	output logic dma_out_valid,
	output hbt_dma_out_s dma_out,
	// translation entry fetch, read only
	output logic mem_rd,
	output logic [63:0] mem_addr,
	input wire logic mem_valid,
	input wire logic mem_err,
	input wire logic [63:0] mem_rdata,
	// buffered data write back for an entry store
	output logic flush_req,
	output logic [19:0] flush_page,
	input wire logic flush_ack,
	// alias and hole controls
	output logic pm_alias_en,
	output logic sm_alias_en,
	output logic io_hole_en
);
	// byte-enable merge of a register write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// address inside the bridge's own peripheral windows
	function automatic logic in_own(input logic [63:0] a, input logic [31:0] pb, input logic [31:0] pt,
			input logic [31:0] ib, input logic [31:0] it);
		return a[63:32] == 32'h0 && ((a[31:0] >= pb && a[31:0] <= pt) || (a[31:0] >= ib && a[31:0] <= it));
	endfunction

	logic [5:0] ctrl;
	logic [31:0] io_window_base;
	logic [31:0] io_window_top;
	logic [31:0] pm_base;
	logic [31:0] pm_top;
	logic [31:0] tce_base;
	logic [11:0] pc_memory_ceiling;
	logic [11:0] exc_base;
	logic [31:0] mem_top;
	logic [2:0] status;
	logic st_pend;
	logic [19:0] st_page;
	logic [31:0] rd_mux;
	logic req;
	logic acc;
	logic wr_ok;
	logic hold;
	hbt_state_e state;
	hbt_state_e next_state;
	hbt_dma_req_s cur;
	logic [63:0] cur_tce;
	logic use_tce;
	logic cache_hit;
	logic [63:0] cache_tce;
	logic [63:0] fetched;
	logic [63:0] clean_tce;
	logic [63:0] xaddr;
	logic [63:0] ceil_addr;
	hbt_res_e res;
	logic pio_io;
	logic pio_sys;
	logic [31:0] pio_addr;
	logic [31:0] ctrl_wr;
	logic [31:0] ceil_wr;
	logic [31:0] exc_wr;

	// bus handshake: a store to the entry register waits while one is still pending
	assign req = avs_read || avs_write;
	assign hold = avs_write && avs_address == `HBT_REG_TCE_STORE && st_pend;
	assign acc = req && !avs_waitrequest;
	assign wr_ok = acc && avs_write;

	// waitrequest drops for one cycle per request, so every access that is not held takes two edges
	always_ff @(posedge clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !(req && avs_waitrequest && !hold);
		end
	end

	// read mux; unmapped offsets read as zero
	always_comb begin
		case (avs_address)
			`HBT_REG_CTRL: rd_mux = {26'h0, ctrl};
			`HBT_REG_IO_BASE: rd_mux = io_window_base;
			`HBT_REG_IO_TOP: rd_mux = io_window_top;
			`HBT_REG_PM_BASE: rd_mux = pm_base;
			`HBT_REG_PM_TOP: rd_mux = pm_top;
			`HBT_REG_TCE_BASE: rd_mux = tce_base;
			`HBT_REG_PC_CEIL: rd_mux = {pc_memory_ceiling, 20'h0};
			`HBT_REG_EXC_BASE: rd_mux = {exc_base, 20'h0};
			`HBT_REG_MEM_TOP: rd_mux = mem_top;
			`HBT_REG_STATUS: rd_mux = {29'h0, status};
			`HBT_REG_TCE_STORE: rd_mux = {11'h0, st_pend, st_page};
			default: rd_mux = 32'h0;
		endcase
	end

	// read data captured as waitrequest drops and held through the sampling edge
	always_ff @(posedge clk) begin
		if (rst) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_mux;
		end
	end

	// merged write words, cut back below to the bits each register keeps
	assign ctrl_wr = merge({26'h0, ctrl}, avs_writedata, avs_byteenable);
	assign ceil_wr = merge({pc_memory_ceiling, 20'h0}, avs_writedata, avs_byteenable);
	assign exc_wr = merge({exc_base, 20'h0}, avs_writedata, avs_byteenable);

	// control word; pc emulation overrides the alias and hole bits
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= `HBT_CTRL_RESET;
		end else if (wr_ok && avs_address == `HBT_REG_CTRL) begin
			ctrl <= ctrl_wr[5:0];
		end else if (ctrl[`HBT_CTRL_PCEMU]) begin
			ctrl[`HBT_CTRL_PM_ALIAS] <= 1'b1;
			ctrl[`HBT_CTRL_SM_ALIAS] <= 1'b0;
			ctrl[`HBT_CTRL_IO_HOLE] <= 1'b1;
		end
	end

	// window and table registers
	always_ff @(posedge clk) begin
		if (rst) begin
			io_window_base <= 32'h0;
			io_window_top <= 32'h0;
			pm_base <= 32'h0;
			pm_top <= 32'h0;
			tce_base <= 32'h0;
			mem_top <= 32'h0;
		end else if (wr_ok) begin
			case (avs_address)
				`HBT_REG_IO_BASE: io_window_base <= merge(io_window_base, avs_writedata, avs_byteenable);
				`HBT_REG_IO_TOP: io_window_top <= merge(io_window_top, avs_writedata, avs_byteenable);
				`HBT_REG_PM_BASE: pm_base <= merge(pm_base, avs_writedata, avs_byteenable);
				`HBT_REG_PM_TOP: pm_top <= merge(pm_top, avs_writedata, avs_byteenable);
				`HBT_REG_TCE_BASE: tce_base <= merge(tce_base, avs_writedata, avs_byteenable);
				`HBT_REG_MEM_TOP: mem_top <= merge(mem_top, avs_writedata, avs_byteenable);
				default: ;
			endcase
		end
	end

	// ceiling and relocation base keep only megabyte bits
	always_ff @(posedge clk) begin
		if (rst) begin
			pc_memory_ceiling <= 12'h0;
			exc_base <= 12'h0;
		end else if (wr_ok && avs_address == `HBT_REG_PC_CEIL) begin
			pc_memory_ceiling <= ceil_wr[31:20];
		end else if (wr_ok && avs_address == `HBT_REG_EXC_BASE) begin
			exc_base <= exc_wr[31:20];
		end
	end

	// sticky outcome flags, write one to clear; a new event wins over the clear
	always_ff @(posedge clk) begin
		if (rst) begin
			status <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (dma_out_valid && dma_out.res == hbt_res_e'(i + 1)) begin
					status[i] <= 1'b1;
				end else if (wr_ok && avs_address == `HBT_REG_STATUS && avs_byteenable[0] && avs_writedata[i]) begin
					status[i] <= 1'b0;
				end
			end
		end
	end

	// a software store to an entry arms the flush sequence
	always_ff @(posedge clk) begin
		if (rst) begin
			st_pend <= 1'b0;
			st_page <= 20'h0;
		end else if (wr_ok && avs_address == `HBT_REG_TCE_STORE) begin
			st_pend <= 1'b1;
			st_page <= avs_writedata[19:0];
		end else if (state == ST_INVAL) begin
			st_pend <= 1'b0;
		end
	end

	// processor path decode
	hbt_pio_xlate #(
		.EXC_SIZE(EXC_SIZE)
	) u_pio (
		.addr(cpu_addr),
		.io_window_base(io_window_base),
		.io_window_top(io_window_top),
		.exc_base({exc_base, 20'h0}),
		.discontig(ctrl[`HBT_CTRL_DISCONTIG]),
		.pcemu(ctrl[`HBT_CTRL_PCEMU]),
		.io_hit(pio_io),
		.sys_hit(pio_sys),
		.out_addr(pio_addr)
	);

	// processor result registered one cycle after the request
	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_out_valid <= 1'b0;
			cpu_out_io <= 1'b0;
			cpu_out_miss <= 1'b0;
			cpu_out_addr <= 32'h0;
		end else begin
			cpu_out_valid <= cpu_valid;
			cpu_out_io <= cpu_valid && pio_io;
			cpu_out_miss <= cpu_valid && !pio_io && !pio_sys;
			cpu_out_addr <= cpu_valid ? pio_addr : 32'h0;
		end
	end

	// alias and hole controls follow the control word
	always_ff @(posedge clk) begin
		if (rst) begin
			pm_alias_en <= 1'b0;
			sm_alias_en <= 1'b0;
			io_hole_en <= 1'b0;
		end else begin
			pm_alias_en <= ctrl[`HBT_CTRL_PM_ALIAS] || ctrl[`HBT_CTRL_PCEMU];
			sm_alias_en <= ctrl[`HBT_CTRL_SM_ALIAS] && !ctrl[`HBT_CTRL_PCEMU];
			io_hole_en <= ctrl[`HBT_CTRL_IO_HOLE] || ctrl[`HBT_CTRL_PCEMU];
		end
	end

	// single-entry cache of translation entries
	hbt_tce_cache u_cache (
		.clk(clk),
		.rst(rst),
		.look_page(cur.addr[31:`HBT_PAGE_BITS]),
		.hit(cache_hit),
		.hit_tce(cache_tce),
		.fill(state == ST_WAIT && mem_valid && !mem_err),
		.fill_page(cur.addr[31:`HBT_PAGE_BITS]),
		.fill_tce(clean_tce),
		.inval(state == ST_INVAL),
		.inval_page(st_page)
	);

	// byte 0 comes in the top lane, so the big-endian entry needs no swap; no-access keeps nothing else
	assign fetched = mem_rdata;
	assign clean_tce = fetched[1:0] == `HBT_PM_NONE ? 64'h0 : fetched;

	// sequencer: entry stores first, then dma requests
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (st_pend) begin
					next_state = ST_FLUSH;
				end else if (dma_valid && dma_ready) begin // untaken requests would answer a stale capture
					next_state = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (ctrl[`HBT_CTRL_DMA64] && !cur.dac && !cache_hit
						&& !in_own(cur.addr, pm_base, pm_top, io_window_base, io_window_top)) begin
					next_state = ST_FETCH;
				end else begin
					next_state = ST_FIN;
				end
			end
			ST_FETCH: next_state = ST_WAIT;
			ST_WAIT: next_state = mem_valid ? ST_FIN : ST_WAIT;
			ST_FIN: next_state = ST_IDLE;
			ST_FLUSH: next_state = flush_ack ? ST_INVAL : ST_FLUSH;
			ST_INVAL: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// state register; ready is high only while the state is idle without a store waiting
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
			dma_ready <= 1'b0;
		end else begin
			state <= next_state;
			dma_ready <= next_state == ST_IDLE && !st_pend && !(wr_ok && avs_address == `HBT_REG_TCE_STORE);
		end
	end

	// request capture and choice of translation path
	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '0;
			use_tce <= 1'b0;
			cur_tce <= 64'h0;
		end else if (state == ST_IDLE && dma_valid && dma_ready) begin
			cur <= dma_req;
			use_tce <= 1'b0;
		end else if (state == ST_CHECK) begin
			use_tce <= ctrl[`HBT_CTRL_DMA64] && !cur.dac;
			cur_tce <= cache_tce;
		end else if (state == ST_WAIT && mem_valid) begin
			cur_tce <= mem_err ? 64'h0 : clean_tce;
		end
	end

	// entry fetch from table base plus eight bytes per page, read only
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_rd <= 1'b0;
			mem_addr <= 64'h0;
		end else if (state == ST_FETCH) begin
			mem_rd <= 1'b1;
			mem_addr <= {32'h0, tce_base} + {41'h0, cur.addr[31:`HBT_PAGE_BITS], 3'h0};
		end else if (mem_valid) begin
			mem_rd <= 1'b0;
		end
	end

	// remembers a fetch error until the answer is built
	logic fetch_err;
	always_ff @(posedge clk) begin
		if (rst) begin
			fetch_err <= 1'b0;
		end else if (state == ST_CHECK) begin
			fetch_err <= 1'b0;
		end else if (state == ST_WAIT && mem_valid) begin
			fetch_err <= mem_err;
		end
	end

	// final address and outcome
	assign ceil_addr = {32'h0, pc_memory_ceiling, 20'hfffff};
	always_comb begin
		if (use_tce) begin
			xaddr = {cur_tce[63:`HBT_PAGE_BITS], cur.addr[`HBT_PAGE_BITS-1:0]};
		end else if (cur.dac && cur.addr[63:32] == `HBT_UPPER_ONES) begin
			xaddr = {32'h0, cur.addr[31:0]};
		end else begin
			xaddr = cur.addr;
		end
		if (use_tce && fetch_err) begin
			res = RES_TCE_ERR;
		end else if (ctrl[`HBT_CTRL_DMA64] && !cur.dac
				&& in_own(cur.addr, pm_base, pm_top, io_window_base, io_window_top)) begin
			res = RES_INVALID;
		end else if (use_tce && cur_tce[1:0] == `HBT_PM_NONE) begin
			res = RES_INVALID;
		end else if (in_own(xaddr, pm_base, pm_top, io_window_base, io_window_top)) begin
			res = RES_INVALID;
		end else if (ctrl[`HBT_CTRL_PCEMU] && xaddr > ceil_addr && xaddr <= {32'h0, mem_top}) begin
			res = PCE_RESPOND ? RES_INVALID : RES_IGNORED;
		end else begin
			res = RES_OK;
		end
	end

	// one-cycle answer toward the host side
	always_ff @(posedge clk) begin
		if (rst) begin
			dma_out_valid <= 1'b0;
			dma_out <= '0;
		end else if (state == ST_FIN) begin
			dma_out_valid <= 1'b1;
			dma_out.addr <= xaddr;
			dma_out.res <= res;
			dma_out.write <= cur.write;
		end else begin
			dma_out_valid <= 1'b0;
		end
	end

	// write back of buffered page data before the entry is dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			flush_req <= 1'b0;
			flush_page <= 20'h0;
		end else if (state == ST_IDLE && st_pend) begin
			flush_req <= 1'b1;
			flush_page <= st_page;
		end else if (flush_ack) begin
			flush_req <= 1'b0;
		end
	end
endmodule

// >>> test/hbt_bridge_assertions.sv
// Purpose: port-level checks of the host bridge translator
// Assumes: one clock, synchronous active-high reset
// Notes: bound into every hbt_bridge instance
module hbt_bridge_chk
	import hbt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register bus and processor path
	input wire logic [5:0] avs_address,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic cpu_valid,
	input wire logic cpu_out_valid,
	// dma path
	input wire logic dma_valid,
	input wire hbt_dma_req_s dma_req,
	input wire logic dma_ready,
	input wire logic dma_out_valid,
	input wire hbt_dma_out_s dma_out,
	// fetch, flush and alias controls
	input wire logic mem_rd,
	input wire logic [63:0] mem_addr,
	input wire logic mem_valid,
	input wire logic mem_err,
	input wire logic [63:0] mem_rdata,
	input wire logic flush_req,
	input wire logic [19:0] flush_page,
	input wire logic flush_ack,
	input wire logic pm_alias_en,
	input wire logic sm_alias_en,
	input wire logic io_hole_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic take, got, dac_hi, pc_on;
	logic [63:0] ent_q;
	// events the properties start from
	assign take = dma_valid && dma_ready;
	assign got = mem_rd && mem_valid;
	assign dac_hi = take && dma_req.dac && (&dma_req.addr[63:32]);
	assign pc_on = avs_write && !avs_waitrequest && avs_address == 6'h00 && avs_byteenable[0] && avs_writedata[2];
	// entry kept because the bus shows garbage once the answer is gone
	always_ff @(posedge clk) begin
		if (got)
			ent_q <= mem_rdata;
	end
	cpu_answer_a: assert property (cpu_out_valid == $past(cpu_valid))
		else $error("cpu answer does not follow its request");
	dac_upper_a: assert property (dac_hi |-> ##[1:5] dma_out_valid && dma_out.addr[63:32] == 32'h0)
		else $error("upper half of dual cycle address not cleared");
	dac_nofetch_a: assert property (take && dma_req.dac |=> !mem_rd [*4])
		else $error("dual cycle access fetched an entry");
	fetch_err_a: assert property (got && mem_err |-> ##[1:3] dma_out_valid && dma_out.res == RES_TCE_ERR)
		else $error("failed fetch not reported");
	no_access_a: assert property (got && !mem_err && mem_rdata[1:0] == 2'h0 |->
		##[1:3] dma_out_valid && dma_out.res == RES_INVALID) else $error("no-access entry not refused");
	entry_page_a: assert property (got && !mem_err && mem_rdata[1:0] != 2'h0 |->
		##[1:3] dma_out_valid && (dma_out.res != RES_OK || dma_out.addr[63:12] == ent_q[63:12]))
		else $error("real page not taken from entry");
	fetch_hold_a: assert property (mem_rd && !mem_valid |=> mem_rd && $stable(mem_addr))
		else $error("fetch request dropped or moved");
	flush_hold_a: assert property (flush_req && !flush_ack |=> flush_req && $stable(flush_page))
		else $error("write back request dropped or moved");
	pc_alias_a: assert property (pc_on |-> ##3 pm_alias_en && !sm_alias_en && io_hole_en)
		else $error("alias controls wrong in emulation");
	cover property (got && mem_err);
	cover property (take && dma_req.dac);
	cover property (flush_req && flush_ack);
endmodule
bind hbt_bridge hbt_bridge_chk u_chk (.clk, .rst, .avs_address, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_waitrequest, .cpu_valid, .cpu_out_valid, .dma_valid, .dma_req, .dma_ready, .dma_out_valid, .dma_out,
	.mem_rd, .mem_addr, .mem_valid, .mem_err, .mem_rdata, .flush_req, .flush_page, .flush_ack,
	.pm_alias_en, .sm_alias_en, .io_hole_en);

// >>> test/hbt_mem_model.sv
// Purpose: system memory and write-back buffer seen by the bridge
// Assumes: entries held as stored, big-endian, byte 0 in the top bits
// Notes: an absent entry answers with an error; dly sets the answer delay
module hbt_mem_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] dly,
	// entry fetch
	input wire logic mem_rd,
	input wire logic [63:0] mem_addr,
	output logic mem_valid,
	output logic mem_err,
	output logic [63:0] mem_rdata,
	// buffer write back
	input wire logic flush_req,
	input wire logic [19:0] flush_page,
	output logic flush_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [63:0] ent [logic [63:0]];
	logic [19:0] fpage;
	logic mdone, fdone;
	logic [2:0] mcnt, fcnt;
	// read only side: the table is only ever changed by software
	always @(posedge clk) begin
		mem_valid <= 1'b0;
		mem_err <= 1'b0;
		mem_rdata <= rst ? 64'h0f0f_0f0f_0f0f_0f0f : ~mem_rdata; // no stale entry on an idle bus
		if (rst || !mem_rd) begin
			mdone <= 1'b0;
			mcnt <= 3'h0;
		end else if (!mdone && mcnt == dly) begin
			mdone <= 1'b1;
			mem_valid <= 1'b1;
			mem_err <= !ent.exists(mem_addr);
			mem_rdata <= ent.exists(mem_addr) ? ent[mem_addr] : ~mem_rdata;
		end else if (!mdone)
			mcnt <= mcnt + 3'h1;
	end
	// write back finishes after the same delay
	always @(posedge clk) begin
		flush_ack <= 1'b0;
		if (rst || !flush_req) begin
			fdone <= 1'b0;
			fcnt <= 3'h0;
		end else if (!fdone && fcnt == dly) begin
			fdone <= 1'b1;
			flush_ack <= 1'b1;
			fpage <= flush_page;
		end else if (!fdone)
			fcnt <= fcnt + 3'h1;
	end
endmodule

// >>> test/hbt_bridge_tb.sv
// Purpose: self-checking bench for the host bridge translator
// Assumes: expected values come from a reference model in the bench
// Notes: windows, table and ceiling at fixed non-overlapping places
module hbt_bridge_tb;
	import hbt_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [63:0] IOB = 64'h8000_0000, IOT = 64'h80ff_ffff, PMB = 64'hc000_0000, PMT = 64'hc0ff_ffff;
	localparam logic [63:0] TCE = 64'h1_0000, CEIL = 64'h010f_ffff, MTOP = 64'h03ff_ffff;
	logic clk, rst, avs_read, avs_write, avs_waitrequest, cpu_valid, cpu_out_valid, cpu_out_io, cpu_out_miss;
	logic dma_valid, dma_ready, dma_out_valid, mem_rd, mem_valid, mem_err, flush_req, flush_ack;
	logic pm_alias_en, sm_alias_en, io_hole_en;
	logic [5:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, cpu_addr, cpu_out_addr, q, r;
	logic [63:0] mem_addr, mem_rdata;
	logic [19:0] flush_page;
	logic [2:0] dly, c;
	hbt_dma_req_s dma_req;
	hbt_dma_out_s dma_out;
	int n_fail, check_count, seed, i;
	logic [37:0] cfg [8] = '{{6'h04, 32'h8000_0000}, {6'h08, 32'h80ff_ffff}, {6'h0c, 32'hc000_0000},
		{6'h10, 32'hc0ff_ffff}, {6'h14, 32'h0001_0000}, {6'h18, 32'h0100_0abc}, {6'h1c, 32'h0020_0000},
		{6'h20, 32'h03ff_ffff}};
	hbt_bridge u_dut (.*);
	hbt_mem_model u_mem (.clk, .rst, .dly, .mem_rd, .mem_addr, .mem_valid, .mem_err, .mem_rdata,
		.flush_req, .flush_page, .flush_ack);
	// free running bench clock
	always #25 clk = ~clk;
	task automatic chk(input string s, input logic [63:0] g, input logic [63:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (a == 6'h00 && w)
			c = d[2:0];
		@(posedge clk); // an edge between release and the next request
	endtask
	task automatic cpu(input logic [31:0] a, input logic [1:0] k, input logic [31:0] x);
		cpu_valid <= 1'b1;
		cpu_addr <= a;
		@(posedge clk);
		cpu_valid <= 1'b0;
		@(posedge clk);
		chk("cpu kind", {cpu_out_valid, cpu_out_io, cpu_out_miss}, {1'b1, k});
		if (!k[0])
			chk("cpu addr", cpu_out_addr, x);
	endtask
	function automatic logic inwin(input logic [63:0] a);
		return (a >= IOB && a <= IOT) || (a >= PMB && a <= PMT);
	endfunction
	// reference translation: {address, result code}
	function automatic logic [65:0] ref_dma(input logic [63:0] a, input logic dac);
		logic [63:0] k;
		k = TCE + {a[31:12], 3'h0};
		if (dac && (&a[63:32]))
			a[63:32] = 32'h0;
		else if (c[1] && !dac) begin
			if (inwin(a))
				return {a, 2'h1};
			if (!u_mem.ent.exists(k))
				return {a, 2'h2};
			if (u_mem.ent[k][1:0] == 2'h0)
				return {a, 2'h1};
			a = {u_mem.ent[k][63:12], a[11:0]};
		end
		return {a, 1'b0, inwin(a) || (c[2] && a > CEIL && a <= MTOP)};
	endfunction
	task automatic dma(input logic [63:0] a, input logic dac);
		logic [65:0] x;
		x = ref_dma(a, dac);
		dly <= 3'($random(seed));
		dma_req <= {a, dac, r[0]};
		dma_valid <= 1'b1;
		do @(posedge clk); while (!dma_ready);
		dma_valid <= 1'b0;
		do @(posedge clk); while (!dma_out_valid);
		chk("dma result", dma_out.res, x[1:0]);
		chk("dma write", dma_out.write, r[0]);
		if (x[1:0] == 2'h0)
			chk("dma addr", dma_out.addr, x[65:2]);
	endtask
	// watchdog for a hung handshake
	initial begin
		#2_000_000;
		n_fail++;
		end_of_test();
	end
	// main sequence
	initial begin
		{clk, avs_read, avs_write, cpu_valid, dma_valid, dly, c, n_fail, check_count} = '0;
		{avs_address, avs_writedata, cpu_addr, dma_req} = '0;
		avs_byteenable = 4'hf;
		seed = 32'h41b2;
		rst = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, 6'h00, 32'h0);
		chk("ctrl reset", q, 32'h0);
		foreach (cfg[j]) bus(1'b1, cfg[j][37:32], cfg[j][31:0]);
		bus(1'b0, 6'h18, 32'h0);
		chk("ceiling", q, 32'h0100_0000);
		bus(1'b0, 6'h14, 32'h0);
		chk("table base", q, TCE[31:0]);
		bus(1'b1, 6'h2c, 32'h5);
		bus(1'b0, 6'h2c, 32'h0);
		chk("unmapped", q, 32'h0);
		for (i = 0; i < 4; i++) begin
			r = $random(seed);
			cpu(IOB[31:0] + r[15:0], 2'b10, {16'h0, r[15:0]});
			cpu(IOB[31:0] + 32'h80_0000 + r[22:0], 2'b10, 32'h80_0000 + r[22:0]);
			cpu(IOB[31:0] + 32'h1_0000 + r[21:0], 2'b01, 32'h0);
		end
		bus(1'b1, 6'h00, 32'h1);
		for (i = 0; i < 4; i++) begin
			r = $random(seed);
			cpu(IOB[31:0] + r[22:0], 2'b10, {16'h0, r[22:12], r[4:0]});
		end
		bus(1'b1, 6'h00, 32'h0);
		dma(64'h0001_2345, 1'b0);
		bus(1'b1, 6'h00, 32'h2);
		u_mem.ent[TCE + 64'h28] = 64'h0000_0001_2345_6003;
		u_mem.ent[TCE + 64'h30] = {$random(seed), $random(seed)} & ~64'h3;
		u_mem.ent[TCE + 64'h40] = 64'h0000_0000_c000_1001;
		r = $random(seed);
		dma({52'h5, r[11:0]}, 1'b0);
		dma({52'h5, ~r[11:0]}, 1'b0);
		dma(64'h6abc, 1'b0);
		dma(64'h7abc, 1'b0);
		dma(64'h8abc, 1'b0);
		dma(IOB + 64'h10, 1'b0);
		dma(64'hffff_ffff_0000_1abc, 1'b1);
		dma(64'h0000_0002_0000_0000, 1'b1);
		dma({52'h5, ~r[11:0]}, 1'b0);
		bus(1'b1, 6'h28, 32'h5);
		u_mem.ent[TCE + 64'h28] = 64'h0000_0000_0077_7003;
		dma({52'h5, r[11:0]}, 1'b0);
		chk("flushed page", u_mem.fpage, 64'h5);
		bus(1'b1, 6'h00, 32'h4);
		repeat (3) @(posedge clk);
		chk("alias", {pm_alias_en, sm_alias_en, io_hole_en}, 3'b101);
		dma(64'h0200_0000, 1'b0);
		dma(CEIL, 1'b0);
		for (i = 0; i < 4; i++) begin
			r = {$random(seed)} % 32'h3000;
			cpu(32'hfff0_0000 + r, 2'b00, 32'h0020_0000 + r);
		end
		cpu(32'hfff0_3000, 2'b01, 32'h0);
		end_of_test();
	end
endmodule
